// ==== hdl/mme_monitor_entry.sv ====
// Operation
// - All host traffic over wired-OR serial pin
// - Mode latched on reset pin rising edge
// - After eight security bytes send ten-zero break
// - Normal monitor needs test voltage and straps
// - Test voltage entry: operating clock divide-by-four
// - Normal monitor: watchdog off while test voltage
// - Test voltage on interrupt pin bypasses clock generator
// - Without test voltage ignore select pins
// - Erased reset vector forces internal reset, monitor
// - Forced monitor survives all but power-on
// - Programmed vector: only test voltage enters monitor
// - Forced monitor: watchdog always disabled
// - Forced, interrupt high: external clock divided four
// - Forced, interrupt low: clock generator enabled
// - Baud rate is bus clock over 256
// - Monitor vectors fetched from the FE page
// - Monitor allows any address, RAM execution
// - Security bytes matched: bypass until power-on
module mme_monitor_entry
   import mme_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic POR,
   input wire logic RESET_PIN_N,
   input wire logic IRQ_TEST_HIGH,
   input wire logic IRQ_LEVEL,
   input wire logic RESET_TEST_HIGH,
   input wire logic SERIAL_COMM_PIN_IN,
   output logic SERIAL_COMM_PIN_OUT,
   output logic SERIAL_COMM_PIN_OE_N,
   input wire logic COMM_SELECT_PIN,
   input wire logic MODE_SELECT_0_PIN,
   input wire logic MODE_SELECT_1_PIN,
   input wire logic VEC_FETCH,
   input wire logic [15:0] VEC_DATA,
   input wire logic RX_BYTE_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic [7:0] STORED_SEC_BYTE,
   output logic [2:0] SEC_INDEX,
   input wire logic BREAK_REQ,
   output logic [1:0] MODE,
   output logic MONITOR_ACTIVE,
   output logic INTERNAL_RESET,
   output logic WATCHDOG_DISABLE,
   output logic CLKGEN_BYPASS,
   output logic CLKGEN_ENABLE,
   output logic OP_CLK_EN,
   output logic BAUD_EN,
   output logic [15:0] RESET_VEC_ADDR,
   output logic [15:0] BREAK_VEC_ADDR,
   output logic SECURITY_BYPASS,
   output logic FULL_ACCESS,
   output logic READY
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] irq_tst_sync;
      logic [1:0] irq_lvl_sync;
      logic [1:0] rst_tst_sync;
      logic [1:0] ser_sync;
      logic [1:0] sel_sync;
      logic [1:0] m0_sync;
      logic [1:0] m1_sync;
      logic rst_prev;
      mme_mode_t mode;
      logic forced_sticky;
      logic entry_irq_low;
      logic entry_tst;
      mme_state_t state;
      logic [3:0] cnt;
      logic sec_ok;
      logic sec_match;
      logic sec_bypass;
      logic int_reset;
      logic [1:0] op_div;
      logic op_en;
      logic [7:0] baud_div;
      logic baud_en;
      logic ser_out;
      logic ser_oe_n;
      logic wdog_dis;
      logic bypass;
      logic cg_en;
      logic [15:0] rvec;
      logic [15:0] bvec;
      logic ready;
      logic mon_act;
   } mme_state_reg_t;

   mme_state_reg_t s_reg;
   mme_state_reg_t s_next;

   logic rst_rise;
   logic monitor;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.rst_sync = {s_reg.rst_sync[0], RESET_PIN_N};
      s_next.irq_tst_sync = {s_reg.irq_tst_sync[0], IRQ_TEST_HIGH};
      s_next.irq_lvl_sync = {s_reg.irq_lvl_sync[0], IRQ_LEVEL};
      s_next.rst_tst_sync = {s_reg.rst_tst_sync[0], RESET_TEST_HIGH};
      s_next.ser_sync = {s_reg.ser_sync[0], SERIAL_COMM_PIN_IN};
      s_next.sel_sync = {s_reg.sel_sync[0], COMM_SELECT_PIN};
      s_next.m0_sync = {s_reg.m0_sync[0], MODE_SELECT_0_PIN};
      s_next.m1_sync = {s_reg.m1_sync[0], MODE_SELECT_1_PIN};
      s_next.rst_prev = s_reg.rst_sync[1];
      rst_rise = s_reg.rst_sync[1] && !s_reg.rst_prev;
      monitor = (s_reg.mode != MODE_USER);
      s_next.int_reset = 1'b0;

      // Mode decode on release edge; straps read only here
      if (rst_rise) begin
         s_next.state = ST_VECTOR;
         s_next.cnt = 4'h0;
         s_next.entry_tst = s_reg.irq_tst_sync[1];
         s_next.entry_irq_low = !s_reg.irq_lvl_sync[1];
         if (s_reg.irq_tst_sync[1] && s_reg.ser_sync[1] && !s_reg.sel_sync[1]
               && s_reg.m0_sync[1] && !s_reg.m1_sync[1]) begin
            s_next.mode = MODE_NORMAL_MON;
         end else if (s_reg.forced_sticky) begin
            s_next.mode = MODE_FORCED_MON;
         end else begin
            s_next.mode = MODE_USER;
         end
      end

      case (s_reg.state)
         ST_RESET: begin
         end
         ST_VECTOR: begin
            // Erased vector seen in user mode: force another reset
            if (VEC_FETCH) begin
               if (s_reg.mode == MODE_USER && VEC_DATA == ERASED_VECTOR) begin
                  s_next.forced_sticky = 1'b1;
                  s_next.int_reset = 1'b1;
                  s_next.mode = MODE_FORCED_MON;
                  s_next.entry_tst = 1'b0;
                  s_next.state = ST_SECURITY;
               end else if (monitor) begin
                  s_next.state = ST_SECURITY;
               end else begin
                  s_next.state = ST_READY;
               end
            end
         end
         ST_SECURITY: begin
            // Non-power-on resets skip the code entry once bypassed
            if (s_reg.sec_ok) begin
               s_next.state = ST_BREAK;
               s_next.cnt = 4'h0;
            end else if (RX_BYTE_VALID) begin
               s_next.sec_match = s_reg.sec_match && (RX_BYTE == STORED_SEC_BYTE);
               s_next.cnt = s_reg.cnt + 4'h1;
               if (s_reg.cnt + 4'h1 == SEC_BYTES_CNT) begin
                  s_next.sec_ok = s_reg.sec_match && (RX_BYTE == STORED_SEC_BYTE);
                  s_next.state = ST_BREAK;
                  s_next.cnt = 4'h0;
               end
            end
         end
         ST_BREAK: begin
            // Pull the line low for ten bit times
            s_next.ser_out = 1'b0;
            s_next.ser_oe_n = 1'b0;
            if (s_reg.baud_en) begin
               s_next.cnt = s_reg.cnt + 4'h1;
               if (s_reg.cnt + 4'h1 == BREAK_BITS_CNT) begin
                  s_next.ser_oe_n = 1'b1;
                  s_next.ser_out = 1'b1;
                  s_next.state = ST_READY;
               end
            end
         end
         ST_READY: begin
            s_next.ready = monitor;
            // Break requests while ready re-send the break
            if (BREAK_REQ && monitor) begin
               s_next.state = ST_BREAK;
               s_next.cnt = 4'h0;
               s_next.ready = 1'b0;
            end
         end
         default: s_next.state = ST_RESET;
      endcase

      if (s_reg.state == ST_SECURITY && s_reg.cnt == 4'h0 && RX_BYTE_VALID) begin
         s_next.sec_match = (RX_BYTE == STORED_SEC_BYTE);
         if (SEC_BYTES_CNT == 4'h1) begin
            s_next.sec_ok = s_next.sec_match;
         end
      end
      s_next.sec_bypass = s_reg.sec_ok && monitor;

      // Clocks: test voltage bypasses generator, quarter rate
      s_next.bypass = s_reg.irq_tst_sync[1];
      s_next.cg_en = !s_reg.irq_tst_sync[1]
         && !(s_reg.mode == MODE_FORCED_MON && !s_reg.entry_irq_low);
      s_next.op_div = s_reg.op_div + 2'h1;
      s_next.op_en = (s_reg.mode == MODE_USER && !s_reg.irq_tst_sync[1])
         || (s_reg.mode == MODE_FORCED_MON && s_reg.entry_irq_low)
         || (s_reg.op_div == OP_DIV_LAST);
      if (s_reg.op_en) begin
         s_next.baud_div = s_reg.baud_div + 8'h01;
      end
      s_next.baud_en = s_reg.op_en && (s_reg.baud_div == BAUD_LAST);

      // Break starts on a fresh bit boundary so all ten bits are full length;
      // a free-running phase would shorten the first zero bit
      if (s_next.state == ST_BREAK && s_reg.state != ST_BREAK) begin
         s_next.op_div = 2'h1;
         s_next.op_en = 1'b0;
         s_next.baud_div = 8'h00;
         s_next.baud_en = 1'b0;
      end

      // Watchdog gating
      case (s_reg.mode)
         MODE_FORCED_MON: s_next.wdog_dis = 1'b1;
         MODE_NORMAL_MON: s_next.wdog_dis = s_reg.irq_tst_sync[1] || s_reg.rst_tst_sync[1];
         default: s_next.wdog_dis = 1'b0;
      endcase

      // Vector remap
      s_next.rvec = monitor ? MON_RESET_VEC : USER_RESET_VEC;
      s_next.bvec = monitor ? MON_BREAK_VEC : USER_BREAK_VEC;
      // Registered so the status pin leaves a flop
      s_next.mon_act = (s_next.mode != MODE_USER);
      if (!s_reg.rst_sync[1]) begin
         s_next.state = ST_RESET;
         s_next.ready = 1'b0;
         s_next.ser_oe_n = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST || POR) begin
         s_reg <= '0;
         // Pin sync starts low: a high pin reads as a release afterwards
         s_reg.rst_sync <= 2'h0;
         s_reg.mode <= MODE_USER;
         s_reg.state <= ST_RESET;
         s_reg.sec_match <= 1'b1;
         s_reg.ser_out <= 1'b1;
         s_reg.ser_oe_n <= 1'b1;
         s_reg.cg_en <= 1'b1;
         s_reg.rvec <= USER_RESET_VEC;
         s_reg.bvec <= USER_BREAK_VEC;
         if (RST && !POR) begin
            s_reg.forced_sticky <= s_reg.forced_sticky;
            s_reg.sec_ok <= s_reg.sec_ok;
         end
      end else begin
         s_reg <= s_next;
      end
   end

   assign SERIAL_COMM_PIN_OUT = s_reg.ser_out;
   assign SERIAL_COMM_PIN_OE_N = s_reg.ser_oe_n;
   assign SEC_INDEX = s_reg.cnt[2:0];
   assign MODE = s_reg.mode;
   assign MONITOR_ACTIVE = s_reg.mon_act;
   assign INTERNAL_RESET = s_reg.int_reset;
   assign WATCHDOG_DISABLE = s_reg.wdog_dis;
   assign CLKGEN_BYPASS = s_reg.bypass;
   assign CLKGEN_ENABLE = s_reg.cg_en;
   assign OP_CLK_EN = s_reg.op_en;
   assign BAUD_EN = s_reg.baud_en;
   assign RESET_VEC_ADDR = s_reg.rvec;
   assign BREAK_VEC_ADDR = s_reg.bvec;
   assign SECURITY_BYPASS = s_reg.sec_bypass;
   assign FULL_ACCESS = s_reg.sec_bypass;
   assign READY = s_reg.ready;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_forced_wdog_off: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.mode == MODE_FORCED_MON |=> WATCHDOG_DISABLE) else $error("watchdog on in forced mode");
   a_user_wdog_on: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.mode == MODE_USER |=> !WATCHDOG_DISABLE) else $error("watchdog off in user mode");
   a_mon_vectors: assert property (@(posedge CLK) disable iff (RST || POR)
      MONITOR_ACTIVE |=> RESET_VEC_ADDR == MON_RESET_VEC && BREAK_VEC_ADDR == MON_BREAK_VEC)
      else $error("monitor vector wrong");
   a_user_vectors: assert property (@(posedge CLK) disable iff (RST || POR)
      !MONITOR_ACTIVE |=> RESET_VEC_ADDR == USER_RESET_VEC) else $error("user vector wrong");
   a_bypass_follow: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.irq_tst_sync[1] |=> CLKGEN_BYPASS) else $error("bypass not set");
   a_mode_stable: assert property (@(posedge CLK) disable iff (RST || POR)
      !rst_rise && s_reg.state != ST_VECTOR |=> $stable(MODE)) else $error("mode changed");
   a_erased_reset: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.state == ST_VECTOR && VEC_FETCH && s_reg.mode == MODE_USER && VEC_DATA == ERASED_VECTOR
      && s_reg.rst_sync[1] |=> INTERNAL_RESET && MODE == MODE_FORCED_MON) else $error("no forced entry");
   a_break_low: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.state == ST_BREAK && s_reg.rst_sync[1] && !(s_reg.baud_en && s_reg.cnt == BREAK_BITS_CNT - 4'h1)
      |=> !SERIAL_COMM_PIN_OE_N) else $error("break not driven");
   a_sec_silent: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.state == ST_SECURITY |=> SERIAL_COMM_PIN_OE_N) else $error("line driven before code");
   a_ready_idle: assert property (@(posedge CLK) disable iff (RST || POR)
      READY |-> SERIAL_COMM_PIN_OE_N) else $error("line driven while ready");

   // ------------------------------------------------------------
   // Checks: clocks
   // ------------------------------------------------------------
   // Only valid away from a mode decode, which may change the rate
   a_op_quarter: assert property (@(posedge CLK) disable iff (RST || POR)
      OP_CLK_EN && MODE == MODE_NORMAL_MON && $past(MODE) == MODE_NORMAL_MON && s_reg.rst_sync[1] && !rst_rise
      |=> !OP_CLK_EN [*3]) else $error("operating rate not quarter");
   a_baud_single: assert property (@(posedge CLK) disable iff (RST || POR)
      BAUD_EN |=> !BAUD_EN) else $error("baud pulse too long");
   a_forced_cgen_off: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.mode == MODE_FORCED_MON && !s_reg.entry_irq_low
      |=> !CLKGEN_ENABLE) else $error("generator on with high interrupt pin");
   a_icg_cgen_on: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.mode == MODE_FORCED_MON && s_reg.entry_irq_low && !s_reg.irq_tst_sync[1]
      |=> CLKGEN_ENABLE) else $error("generator off with low interrupt pin");
   a_unbypass: assert property (@(posedge CLK) disable iff (RST || POR)
      !s_reg.irq_tst_sync[1] |=> !CLKGEN_BYPASS) else $error("bypass left on");

   // ------------------------------------------------------------
   // Checks: entry
   // ------------------------------------------------------------
   a_normal_wdog: assert property (@(posedge CLK) disable iff (RST || POR)
      s_reg.mode == MODE_NORMAL_MON && (s_reg.irq_tst_sync[1] || s_reg.rst_tst_sync[1])
      |=> WATCHDOG_DISABLE) else $error("watchdog on under test voltage");
   a_sticky_forced: assert property (@(posedge CLK) disable iff (RST || POR)
      rst_rise && s_reg.forced_sticky && !s_reg.irq_tst_sync[1]
      |=> MODE == MODE_FORCED_MON) else $error("forced mode lost on reset");
   a_straps_ignored: assert property (@(posedge CLK) disable iff (RST || POR)
      rst_rise && !s_reg.irq_tst_sync[1] && !s_reg.forced_sticky
      |=> MODE == MODE_USER) else $error("straps decoded without test voltage");
   a_int_pulse: assert property (@(posedge CLK) disable iff (RST || POR)
      INTERNAL_RESET |=> !INTERNAL_RESET) else $error("internal reset too long");
   a_user_no_access: assert property (@(posedge CLK) disable iff (RST || POR)
      !MONITOR_ACTIVE |=> !FULL_ACCESS) else $error("full access in user mode");
endmodule // mme_monitor_entry

// ==== hdl/mme_pkg.sv ====
package mme_pkg;
   // ------------------------------------------------------------
   // Mode encoding
   // ------------------------------------------------------------
   typedef enum logic [1:0] {MODE_USER, MODE_NORMAL_MON, MODE_FORCED_MON} mme_mode_t;

   typedef enum {ST_RESET, ST_VECTOR, ST_SECURITY, ST_BREAK, ST_READY} mme_state_t;

   // ------------------------------------------------------------
   // Vector addresses
   // ------------------------------------------------------------
   localparam logic [15:0] USER_RESET_VEC = 16'hfffe;
   localparam logic [15:0] USER_BREAK_VEC = 16'hfffc;
   localparam logic [15:0] MON_RESET_VEC = 16'hfefe;
   localparam logic [15:0] MON_BREAK_VEC = 16'hfefc;
   localparam logic [15:0] ERASED_VECTOR = 16'hffff;
   localparam logic [15:0] SECURITY_BASE = 16'hfff6;

   // ------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------
   localparam int SECURITY_BYTES = 8;
   localparam int BREAK_BITS = 10;
   localparam int BAUD_DIVIDE = 256;
   localparam int OP_DIVIDE = 4;
   localparam logic [3:0] BREAK_BITS_CNT = 4'ha;
   localparam logic [3:0] SEC_BYTES_CNT = 4'h8;
   localparam logic [7:0] BAUD_LAST = 8'hff;
   localparam logic [1:0] OP_DIV_LAST = 2'h3;
   localparam logic [15:0] VEC_LOW_MASK = 16'hfffe;
endpackage

// ==== tb/mme_host_model.sv ====
// ----------------------------------------
// Host side: straps, reset pin, byte sender
// ----------------------------------------
module mme_host_model (
   input wire logic clk,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   output logic line,
   output logic reset_pin_n,
   output logic irq_test_high,
   output logic irq_level,
   output logic reset_test_high,
   output logic [2:0] straps,
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 100ps;

   // Pullup wins when released; host itself idles high
   assign line = dev_oe_n ? 1'b1 : dev_out;

   initial begin
      reset_pin_n = 1'b0;
      {irq_test_high, irq_level, reset_test_high} = 3'h0;
      straps = 3'h0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end

   task volt(input logic t, input logic rt);
      @(posedge clk);
      irq_test_high <= t;
      reset_test_high <= rt;
   endtask

   // Straps first, then reset low-high; 6 edges cover sync, decode, vectors
   task enter(input logic t, input logic lvl, input logic [2:0] s);
      @(posedge clk);
      irq_test_high <= t;
      irq_level <= lvl;
      straps <= s;
      reset_pin_n <= 1'b0;
      repeat (10) @(posedge clk);
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      straps <= ~s;
   endtask

   task send(input logic [7:0] base);
      for (int i = 0; i < 8; i++) begin
         repeat (4) @(posedge clk);
         rx_valid <= 1'b1;
         rx_byte <= base + 8'(i);
         @(posedge clk);
         rx_valid <= 1'b0;
      end
   endtask
endmodule // mme_host_model

// ==== tb/mme_monitor_entry_bench.sv ====
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module mme_monitor_entry_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import mme_pkg::*;

   logic clk, rst, por, vec_fetch, rx_valid, sci, sco, oe_n, rpin, ith, irl, rth, intrst, wdog;
   logic bypass, cg_en, op_en, baud_en, secbyp, full, ready;
   logic [2:0] straps, sec_index;
   logic [7:0] rx_byte, stored;
   logic [15:0] vec_data, rvec, bvec;
   logic [1:0] mode;
   int err_count = 0, compares = 0, cycles = 0, a, b, c;

   // Stored security code is a plain ramp so the host can match it
   assign stored = 8'ha0 + {5'h00, sec_index};

   mme_host_model host (.clk(clk), .dev_out(sco), .dev_oe_n(oe_n), .line(sci), .reset_pin_n(rpin),
      .irq_test_high(ith), .irq_level(irl), .reset_test_high(rth), .straps(straps), .rx_valid(rx_valid),
      .rx_byte(rx_byte));

   mme_monitor_entry uut (.CLK(clk), .RST(rst), .POR(por), .RESET_PIN_N(rpin), .IRQ_TEST_HIGH(ith),
      .IRQ_LEVEL(irl), .RESET_TEST_HIGH(rth), .SERIAL_COMM_PIN_IN(sci), .SERIAL_COMM_PIN_OUT(sco),
      .SERIAL_COMM_PIN_OE_N(oe_n), .COMM_SELECT_PIN(straps[2]), .MODE_SELECT_0_PIN(straps[1]),
      .MODE_SELECT_1_PIN(straps[0]), .VEC_FETCH(vec_fetch), .VEC_DATA(vec_data), .RX_BYTE_VALID(rx_valid),
      .RX_BYTE(rx_byte), .STORED_SEC_BYTE(stored), .SEC_INDEX(sec_index), .BREAK_REQ(1'b0), .MODE(mode),
      .MONITOR_ACTIVE(), .INTERNAL_RESET(intrst), .WATCHDOG_DISABLE(wdog), .CLKGEN_BYPASS(bypass),
      .CLKGEN_ENABLE(cg_en), .OP_CLK_EN(op_en), .BAUD_EN(baud_en), .RESET_VEC_ADDR(rvec),
      .BREAK_VEC_ADDR(bvec), .SECURITY_BYPASS(secbyp), .FULL_ACCESS(full), .READY(ready));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------
   // Shared steps
   // ----------------------------------------
   task power(input logic t, input logic lvl, input logic [2:0] s);
      @(posedge clk);
      por <= 1'b1;
      @(posedge clk);
      por <= 1'b0;
      host.enter(t, lvl, s);
   endtask

   task fetch(input logic [15:0] v);
      @(posedge clk);
      vec_fetch <= 1'b1;
      vec_data <= v;
      @(posedge clk);
      vec_fetch <= 1'b0;
   endtask

   // Counts enable pulses and internal resets over a window
   task count(input int n, output int ops, output int bauds, output int hits);
      ops = 0;
      bauds = 0;
      hits = 0;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         ops += (op_en === 1'b1);
         bauds += (baud_en === 1'b1);
         hits += (intrst === 1'b1);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_normal;
      power(1'b1, 1'b1, 3'b010);
      fetch(16'h1234);
      `CHK("mode", MODE_NORMAL_MON, mode)
      `CHK("bypass", 1'b1, bypass)
      `CHK("rvec", MON_RESET_VEC, rvec)
      `CHK("bvec", MON_BREAK_VEC, bvec)
      count(400, a, b, c);
      `CHK("ops", 100, a)
      count(2048, a, b, c);
      `CHK("bauds", 2, b)
      `CHK("latched", MODE_NORMAL_MON, mode)
      host.send(8'ha0);
      a = 0;
      for (int w = 0; w < 20000 && ready !== 1'b1; w++) begin
         @(negedge clk);
         a += (sci === 1'b0);
      end
      `CHK("break", 10240, a)
      `CHK("ready", 1'b1, ready)
      `CHK("secpass", 1'b1, secbyp)
      `CHK("full", 1'b1, full)
      host.volt(1'b0, 1'b1);
      repeat (4) @(posedge clk);
      `CHK("wdog_rst", 1'b1, wdog)
      `CHK("unbypass", 1'b0, bypass)
      host.volt(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      `CHK("wdog_off", 1'b0, wdog)
   endtask

   task t_user;
      power(1'b0, 1'b1, 3'b010);
      fetch(16'h1234);
      count(30, a, b, c);
      `CHK("intrst", 0, c)
      `CHK("mode", MODE_USER, mode)
      `CHK("wdog", 1'b0, wdog)
      `CHK("rvec", USER_RESET_VEC, rvec)
      `CHK("bvec", USER_BREAK_VEC, bvec)
   endtask

   task t_forced(input logic lvl);
      power(1'b0, lvl, 3'b101);
      fetch(ERASED_VECTOR);
      count(50, a, b, c);
      `CHK("intrst", 1, c)
      `CHK("mode", MODE_FORCED_MON, mode)
      `CHK("wdog", 1'b1, wdog)
      `CHK("cg_en", ~lvl, cg_en)
      count(400, a, b, c);
      if (lvl) `CHK("ops", 100, a)
      else `CHK("ops", 400, a)
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      host.enter(1'b0, lvl, 3'b000);
      `CHK("stay", MODE_FORCED_MON, mode)
      `CHK("wdog2", 1'b1, wdog)
      fetch(ERASED_VECTOR);
      host.send(8'h55);
      repeat (10) @(posedge clk);
      `CHK("secfail", 1'b0, secbyp)
   endtask

   task report_and_stop;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Whole run is about 14k cycles; ceiling leaves ample margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         report_and_stop;
      end
   end

   initial begin
      {rst, por, vec_fetch} = 3'h7;
      vec_fetch = 1'b0;
      vec_data = 16'h0000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      t_normal;
      t_user;
      t_forced(1'b1);
      t_forced(1'b0);
      t_user;
      report_and_stop;
   end
endmodule // mme_monitor_entry_bench
